// >>> rtl/stcd_regs.svh
`ifndef STCD_REGS_SVH
`define STCD_REGS_SVH

// ----------------------------------------------------------------
// Active configuration locations (page, byte lane)
// ----------------------------------------------------------------
`define STCD_PG_INPUT     8'h2C
`define STCD_LN_INPUT     2'h0
`define STCD_PG_RADIO     8'h2C
`define STCD_LN_RADIO     2'h1
`define STCD_PG_BLE       8'h30
`define STCD_LN_BLE       2'h0
`define STCD_PG_CHAN      8'h32
`define STCD_PG_USR_LO    8'h34
`define STCD_PG_USR_HI    8'h35

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STCD_IN_POL       0
`define STCD_IN_AUXA_DIS  1
`define STCD_IN_AUXB_DIS  2
`define STCD_RD_PROTO     0
`define STCD_RD_PWR       4
`define STCD_BT_PLAN_HI   2
`define STCD_BT_RATE      3
`define STCD_BT_SPACING   4
`define STCD_BT_ADDR      5
`define STCD_BT_ENC       6

// ----------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------
`define STCD_MASK_INPUT   8'h07
`define STCD_MASK_RADIO   8'h11
`define STCD_MASK_BLE     8'h7F
`define STCD_RST_CFG      8'h00
`define STCD_RST_CH1      7'h25
`define STCD_RST_CH2      7'h26
`define STCD_RST_CH3      7'h27
`define STCD_RST_USR      8'h00

`endif

// >>> rtl/stcd_pkg.sv
package stcd_pkg;

    // Pin order in the synchroniser vectors
    typedef enum logic [1:0] {
        STCD_PIN_AWAY   = 2'b00,
        STCD_PIN_TOWARD = 2'b01,
        STCD_PIN_AUXA   = 2'b10,
        STCD_PIN_AUXB   = 2'b11
    } stcd_pin_t;

    // Whole state of the decoder
    typedef struct packed {
        logic [3:0]       s1;
        logic [3:0]       s2;
        logic [3:0]       s3;
        logic [3:0]       stab;
        logic [7:0]       input_setup;
        logic [7:0]       radio_setup;
        logic [7:0]       ble_transmit_setup;
        logic [2:0][6:0]  chan;
        logic [7:0][7:0]  usr;
        logic [7:0]       rd_data;
        logic             press;
        logic             release_ev;
        logic             auxa;
        logic             auxb;
        logic             proto_zgp;
        logic             pwr_low;
        logic             rate_2m;
        logic             spacing_10ms;
        logic             addr_rpa;
        logic             enc_user;
        logic             comm_adv;
        logic [1:0]       comm_cnt;
        logic             data_adv;
        logic [1:0]       data_cnt;
        logic             plan_rsvd;
        logic [7:0]       status_val;
    } stcd_state_t;

endpackage : stcd_pkg

// >>> rtl/stcd_chan_plan.sv
`timescale 1ns/10ps
`default_nettype none
`include "stcd_regs.svh"

module stcd_chan_plan
    import stcd_pkg::*;
(
    input  wire logic [2:0] plan,
    output logic            comm_adv,
    output logic [1:0]      comm_cnt,
    output logic            data_adv,
    output logic [1:0]      data_cnt,
    output logic            plan_rsvd
);

    // --------------------------------------------------------------
    // Channel plan decode; count is custom channels from the first
    // --------------------------------------------------------------
    always_comb begin
        comm_adv  = 1'b1;
        comm_cnt  = 2'h0;
        data_adv  = 1'b1;
        data_cnt  = 2'h0;
        plan_rsvd = 1'b0;
        case (plan)
            3'h0: begin                  // R9
                data_adv = 1'b1;
            end
            3'h1: begin                  // R10
                data_adv = 1'b0;
                data_cnt = 2'h3;
            end
            3'h2: begin                  // R10
                data_adv = 1'b0;
                data_cnt = 2'h2;
            end
            3'h3: begin                  // R10
                data_adv = 1'b0;
                data_cnt = 2'h1;
            end
            3'h4: begin                  // R11
                comm_adv = 1'b0;
                comm_cnt = 2'h3;
                data_adv = 1'b0;
                data_cnt = 2'h3;
            end
            3'h5: begin                  // R11
                comm_adv = 1'b0;
                comm_cnt = 2'h2;
                data_adv = 1'b0;
                data_cnt = 2'h2;
            end
            3'h6: begin                  // R11
                comm_adv = 1'b0;
                comm_cnt = 2'h1;
                data_adv = 1'b0;
                data_cnt = 2'h1;
            end
            default: begin
                // Reserved code falls back to the advertising channels
                plan_rsvd = 1'b1;
            end
        endcase
    end

endmodule : stcd_chan_plan
`default_nettype wire

// >>> rtl/stcd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "stcd_regs.svh"

// What this block does
// R1 - Polarity 0: away is press, toward release
// R2 - Polarity 1: press and release swapped
// R3 - Disable bit forces contact A unconnected
// R4 - Disable bit forces contact B unconnected
// R5 - Writer keeps reserved bits at zero
// R6 - All three settings reset to zero
// R7 - Protocol bit picks first or second telegram
// R8 - Power bit selects +4 or 0 dBm
// R9 - Plan 000: everything on advertising channels
// R10 - Plans 001-011: data on custom channels
// R11 - Plans 100-110: all on custom channels
// R12 - Rate bit selects 1 or 2 Mbit/s
// R13 - Spacing bit selects 20 or 10 ms
// R14 - Address bit selects static or private address
// R15 - Encoding bit selects standard or user values
// R16 - Run from active settings; reader only reads
// R17 - Custom channels reset to 0x25, 0x26, 0x27
// R18 - User value indexed by current input status
// R19 - Radio, plan and status outputs change only at input events
module stcd_top
    import stcd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       spring_away_pin,
    input  wire logic       spring_toward_pin,
    input  wire logic       aux_contact_a_pin,
    input  wire logic       aux_contact_b_pin,
    input  wire logic       tx_busy,
    input  wire logic       upd_we,
    input  wire logic [7:0] upd_page,
    input  wire logic [1:0] upd_lane,
    input  wire logic [7:0] upd_data,
    input  wire logic [7:0] nfc_rd_page,
    input  wire logic [1:0] nfc_rd_lane,
    output logic [7:0]      nfc_rd_data,
    output logic            press_evt,
    output logic            release_evt,
    output logic            aux_a_conn,
    output logic            aux_b_conn,
    output logic            proto_zgp,
    output logic            tx_pwr_low,
    output logic            air_rate_2m,
    output logic            spacing_10ms,
    output logic            addr_rpa,
    output logic            status_user,
    output logic            comm_on_adv,
    output logic [1:0]      comm_custom_cnt,
    output logic            data_on_adv,
    output logic [1:0]      data_custom_cnt,
    output logic            plan_reserved,
    output logic [6:0]      custom_channel_one,
    output logic [6:0]      custom_channel_two,
    output logic [6:0]      custom_channel_three,
    output logic [7:0]      status_value
);

    stcd_state_t st_r;
    stcd_state_t st_nxt;
    logic        away_ev;
    logic        toward_ev;
    logic        take_ev;
    logic [2:0]  stat_idx;
    logic [7:0]  user_val;
    logic        pl_comm_adv;
    logic [1:0]  pl_comm_cnt;
    logic        pl_data_adv;
    logic [1:0]  pl_data_cnt;
    logic        pl_rsvd;

    // ----------------------------------------------------------------
    // Channel plan decode of the live setting
    // ----------------------------------------------------------------
    stcd_chan_plan stcd_chan_plan_inst (
        .plan      (st_r.ble_transmit_setup[`STCD_BT_PLAN_HI:0]),
        .comm_adv  (pl_comm_adv),
        .comm_cnt  (pl_comm_cnt),
        .data_adv  (pl_data_adv),
        .data_cnt  (pl_data_cnt),
        .plan_rsvd (pl_rsvd)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Three-stage synchroniser; only stages two and three judge a change
        st_nxt.s1 = {aux_contact_b_pin, aux_contact_a_pin, spring_toward_pin, spring_away_pin};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 4; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.stab[i] = st_r.s3[i];
            end
        end
        away_ev   = st_nxt.stab[STCD_PIN_AWAY] & ~st_r.stab[STCD_PIN_AWAY];
        toward_ev = st_nxt.stab[STCD_PIN_TOWARD] & ~st_r.stab[STCD_PIN_TOWARD];
        // Press direction follows the polarity bit
        if (st_r.input_setup[`STCD_IN_POL]) begin
            st_nxt.press      = toward_ev;                              // R2
            st_nxt.release_ev = away_ev;                                // R2
        end else begin
            st_nxt.press      = away_ev;                                // R1
            st_nxt.release_ev = toward_ev;                              // R1
        end
        // A disabled contact always reads as not connected
        st_nxt.auxa = st_r.stab[STCD_PIN_AUXA] & ~st_r.input_setup[`STCD_IN_AUXA_DIS];  // R3
        st_nxt.auxb = st_r.stab[STCD_PIN_AUXB] & ~st_r.input_setup[`STCD_IN_AUXB_DIS];  // R4
        // Index: contacts plus release flag, so idle contacts and press give 0
        stat_idx = {st_nxt.auxb, st_nxt.auxa, st_nxt.release_ev};
        user_val = st_r.usr[stat_idx];                                  // R18
        // Snapshot only at an accepted event so a telegram in flight sees
        // one consistent setting; events during a busy transmitter still pulse but take no snapshot
        take_ev = (st_nxt.press | st_nxt.release_ev) & ~tx_busy;        // R19
        if (take_ev) begin
            st_nxt.proto_zgp    = st_r.radio_setup[`STCD_RD_PROTO];     // R7
            st_nxt.pwr_low      = st_r.radio_setup[`STCD_RD_PWR];       // R8
            st_nxt.rate_2m      = st_r.ble_transmit_setup[`STCD_BT_RATE];     // R12
            st_nxt.spacing_10ms = st_r.ble_transmit_setup[`STCD_BT_SPACING];  // R13
            st_nxt.addr_rpa     = st_r.ble_transmit_setup[`STCD_BT_ADDR];     // R14
            st_nxt.enc_user     = st_r.ble_transmit_setup[`STCD_BT_ENC];      // R15
            st_nxt.comm_adv     = pl_comm_adv;
            st_nxt.comm_cnt     = pl_comm_cnt;
            st_nxt.data_adv     = pl_data_adv;
            st_nxt.data_cnt     = pl_data_cnt;
            st_nxt.plan_rsvd    = pl_rsvd;
            st_nxt.status_val   = st_r.ble_transmit_setup[`STCD_BT_ENC] ?
                                  user_val : {5'h00, stat_idx};         // R15
        end
        // Update path from the configuration process; reserved bits dropped
        if (upd_we) begin
            if (upd_page == `STCD_PG_INPUT && upd_lane == `STCD_LN_INPUT) begin
                st_nxt.input_setup = upd_data & `STCD_MASK_INPUT;
            end
            if (upd_page == `STCD_PG_RADIO && upd_lane == `STCD_LN_RADIO) begin
                st_nxt.radio_setup = upd_data & `STCD_MASK_RADIO;
            end
            if (upd_page == `STCD_PG_BLE && upd_lane == `STCD_LN_BLE) begin
                st_nxt.ble_transmit_setup = upd_data & `STCD_MASK_BLE;
            end
            if (upd_page == `STCD_PG_CHAN && upd_lane != 2'h3) begin
                st_nxt.chan[upd_lane] = upd_data[6:0];
            end
            if (upd_page == `STCD_PG_USR_LO || upd_page == `STCD_PG_USR_HI) begin
                st_nxt.usr[{upd_page[0], upd_lane}] = upd_data;
            end
        end
        // Reader port has no write path; unmapped bytes read zero
        st_nxt.rd_data = 8'h00;                                         // R16
        case (nfc_rd_page)
            `STCD_PG_INPUT: begin
                if (nfc_rd_lane == `STCD_LN_INPUT) begin
                    st_nxt.rd_data = st_r.input_setup;
                end else if (nfc_rd_lane == `STCD_LN_RADIO) begin
                    st_nxt.rd_data = st_r.radio_setup;
                end
            end
            `STCD_PG_BLE: begin
                if (nfc_rd_lane == `STCD_LN_BLE) begin
                    st_nxt.rd_data = st_r.ble_transmit_setup;
                end
            end
            `STCD_PG_CHAN: begin
                if (nfc_rd_lane != 2'h3) begin
                    st_nxt.rd_data = {1'b0, st_r.chan[nfc_rd_lane]};
                end
            end
            `STCD_PG_USR_LO, `STCD_PG_USR_HI: begin
                st_nxt.rd_data = st_r.usr[{nfc_rd_page[0], nfc_rd_lane}];
            end
            default: begin
                st_nxt.rd_data = 8'h00;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r                    <= '0;
            st_r.input_setup        <= `STCD_RST_CFG;                   // R6
            st_r.radio_setup        <= `STCD_RST_CFG;                   // R6
            st_r.ble_transmit_setup <= `STCD_RST_CFG;                   // R6
            st_r.chan[0]            <= `STCD_RST_CH1;                   // R17
            st_r.chan[1]            <= `STCD_RST_CH2;                   // R17
            st_r.chan[2]            <= `STCD_RST_CH3;                   // R17
            st_r.usr                <= {8{`STCD_RST_USR}};
            st_r.comm_adv           <= 1'b1;
            st_r.data_adv           <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign nfc_rd_data          = st_r.rd_data;
    assign press_evt            = st_r.press;
    assign release_evt          = st_r.release_ev;
    assign aux_a_conn           = st_r.auxa;
    assign aux_b_conn           = st_r.auxb;
    assign proto_zgp            = st_r.proto_zgp;
    assign tx_pwr_low           = st_r.pwr_low;
    assign air_rate_2m          = st_r.rate_2m;
    assign spacing_10ms         = st_r.spacing_10ms;
    assign addr_rpa             = st_r.addr_rpa;
    assign status_user          = st_r.enc_user;
    assign comm_on_adv          = st_r.comm_adv;
    assign comm_custom_cnt      = st_r.comm_cnt;
    assign data_on_adv          = st_r.data_adv;
    assign data_custom_cnt      = st_r.data_cnt;
    assign plan_reserved        = st_r.plan_rsvd;
    assign custom_channel_one   = st_r.chan[0];
    assign custom_channel_two   = st_r.chan[1];
    assign custom_channel_three = st_r.chan[2];
    assign status_value         = st_r.status_val;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    pol_std_a: assert property (@(posedge clk_sys) disable iff (!rstn)   // R1
        away_ev && !st_r.input_setup[0] |=> press_evt && !release_evt)
        else $error("away movement not taken as press");
    pol_inv_a: assert property (@(posedge clk_sys) disable iff (!rstn)   // R2
        away_ev && st_r.input_setup[0] |=> release_evt && !press_evt)
        else $error("inverted polarity not applied");
    aux_a_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R3
        st_r.input_setup[1] |=> !aux_a_conn)
        else $error("disabled contact A seen connected");
    aux_b_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
        st_r.input_setup[2] |=> !aux_b_conn)
        else $error("disabled contact B seen connected");
    proto_snap_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
        take_ev |=> proto_zgp == $past(st_r.radio_setup[0]) &&
                    tx_pwr_low == $past(st_r.radio_setup[4]))
        else $error("radio settings not captured at event");
    plan_adv_a: assert property (@(posedge clk_sys) disable iff (!rstn)  // R9
        take_ev && st_r.ble_transmit_setup[2:0] == 3'h0 |=> comm_on_adv && data_on_adv)
        else $error("plan zero left advertising channels");
    plan_one_a: assert property (@(posedge clk_sys) disable iff (!rstn)  // R11
        take_ev && st_r.ble_transmit_setup[2:0] == 3'h6
        |=> !comm_on_adv && comm_custom_cnt == 2'h1 && data_custom_cnt == 2'h1)
        else $error("plan six not on first custom channel");
    user_val_a: assert property (@(posedge clk_sys) disable iff (!rstn)  // R18
        take_ev && st_r.ble_transmit_setup[6] |=> status_value == $past(user_val))
        else $error("user status value not selected");
    hold_cfg_a: assert property (@(posedge clk_sys) disable iff (!rstn)  // R19
        !take_ev |=> $stable(proto_zgp) && $stable(air_rate_2m) && $stable(status_value))
        else $error("decoded setting changed between events");
    nfc_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)  // R16
        nfc_rd_page == 8'h2C && nfc_rd_lane == 2'h0 |=> nfc_rd_data == $past(st_r.input_setup))
        else $error("reader port returned wrong byte");

endmodule : stcd_top
`default_nettype wire

// >>> tb/stcd_tx_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Transmitter stand-in
// ----------------------------------------------------------------
module stcd_tx_model (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic press_evt,
    input  wire logic release_evt,
    input  wire logic hold_busy,
    output logic      tx_busy
);
    int busy_cnt = 0;

    // Busy for a telegram after every event; hold_busy stalls it on demand
    always @(negedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_cnt <= 0;
        end else if (press_evt || release_evt) begin
            busy_cnt <= 12;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end

    // Driven off the falling edge, like every other input of the block
    assign tx_busy = hold_busy || (busy_cnt != 0);
endmodule : stcd_tx_model

`default_nettype wire

// >>> tb/switch_tx_config_decode_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "stcd_regs.svh"

module switch_tx_config_decode_tb_top;
    logic       clk_sys, rstn, hold_busy, tx_busy;
    logic       spring_away_pin, spring_toward_pin, aux_contact_a_pin, aux_contact_b_pin;
    logic       upd_we;
    logic [7:0] upd_page, upd_data, nfc_rd_page, nfc_rd_data, status_value;
    logic [1:0] upd_lane, nfc_rd_lane, comm_custom_cnt, data_custom_cnt;
    logic       press_evt, release_evt, aux_a_conn, aux_b_conn, proto_zgp, tx_pwr_low;
    logic       air_rate_2m, spacing_10ms, addr_rpa, status_user;
    logic       comm_on_adv, data_on_adv, plan_reserved;
    logic [6:0] custom_channel_one, custom_channel_two, custom_channel_three;
    logic [7:0] plan_byte;
    int         num_errors = 0;
    int         comparisons = 0;
    // Expected {0, reserved, comm_adv, comm_cnt, data_adv, data_cnt} per plan code
    logic [7:0] plan_exp [8] = '{8'h24, 8'h23, 8'h22, 8'h21, 8'h1B, 8'h12, 8'h09, 8'h64};

    assign plan_byte = {1'b0, plan_reserved, comm_on_adv, comm_custom_cnt,
                        data_on_adv, data_custom_cnt};

    stcd_top stcd_top_inst (.clk_sys(clk_sys), .rstn(rstn), .spring_away_pin(spring_away_pin),
        .spring_toward_pin(spring_toward_pin), .aux_contact_a_pin(aux_contact_a_pin),
        .aux_contact_b_pin(aux_contact_b_pin), .tx_busy(tx_busy), .upd_we(upd_we),
        .upd_page(upd_page), .upd_lane(upd_lane), .upd_data(upd_data),
        .nfc_rd_page(nfc_rd_page), .nfc_rd_lane(nfc_rd_lane), .nfc_rd_data(nfc_rd_data),
        .press_evt(press_evt), .release_evt(release_evt), .aux_a_conn(aux_a_conn),
        .aux_b_conn(aux_b_conn), .proto_zgp(proto_zgp), .tx_pwr_low(tx_pwr_low),
        .air_rate_2m(air_rate_2m), .spacing_10ms(spacing_10ms), .addr_rpa(addr_rpa),
        .status_user(status_user), .comm_on_adv(comm_on_adv),
        .comm_custom_cnt(comm_custom_cnt), .data_on_adv(data_on_adv),
        .data_custom_cnt(data_custom_cnt), .plan_reserved(plan_reserved),
        .custom_channel_one(custom_channel_one), .custom_channel_two(custom_channel_two),
        .custom_channel_three(custom_channel_three), .status_value(status_value));

    stcd_tx_model stcd_tx_model_inst (.clk_sys(clk_sys), .rstn(rstn), .press_evt(press_evt),
        .release_evt(release_evt), .hold_busy(hold_busy), .tx_busy(tx_busy));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask : chk_bit

    // One byte from the update process; the writer keeps reserved bits at zero
    task automatic wr(input logic [7:0] pg, input logic [1:0] ln, input logic [7:0] d);
        @(negedge clk_sys);
        upd_we = 1'b1;
        upd_page = pg;
        upd_lane = ln;
        upd_data = d;
        @(negedge clk_sys);
        upd_we = 1'b0;
    endtask : wr

    // Reader data arrives one edge after the address
    task automatic rd(input logic [7:0] pg, input logic [1:0] ln, input logic [7:0] exp);
        @(negedge clk_sys);
        nfc_rd_page = pg;
        nfc_rd_lane = ln;
        @(negedge clk_sys);
        chk("nfc_rd_data", exp, nfc_rd_data);
    endtask : rd

    // Set contacts, move the spring, expect a press or release pulse
    task automatic ev(input logic toward, input logic a, input logic b, input logic exp_press);
        int n;
        aux_contact_a_pin = a;
        aux_contact_b_pin = b;
        repeat (6) @(negedge clk_sys);
        spring_toward_pin = toward;
        spring_away_pin = !toward;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (press_evt !== 1'b1 && release_evt !== 1'b1 && n < 10);
        chk_bit("press_evt", exp_press, press_evt);
        chk_bit("release_evt", !exp_press, release_evt);
        spring_toward_pin = 1'b0;
        spring_away_pin = 1'b0;
        // Busy rises in the model at this very edge, so look one edge later
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (tx_busy === 1'b1 && n < 20);
        repeat (4) @(negedge clk_sys);
    endtask : ev

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(`STCD_PG_INPUT, `STCD_LN_INPUT, 8'h00);
        rd(`STCD_PG_RADIO, `STCD_LN_RADIO, 8'h00);
        rd(`STCD_PG_BLE, `STCD_LN_BLE, 8'h00);
        chk("plan", 8'h24, plan_byte);
        for (int i = 0; i < 3; i++) begin
            rd(`STCD_PG_CHAN, 2'(i), 8'h25 + 8'(i));
        end
        chk("chan_two", 8'h26, {1'b0, custom_channel_two});
        chk("chan_three", 8'h27, {1'b0, custom_channel_three});
        rd(8'h2D, 2'h0, 8'h00);
        wr(`STCD_PG_CHAN, 2'h0, 8'h7F);
        rd(`STCD_PG_CHAN, 2'h0, 8'h7F);
        chk("chan_one", 8'h7F, {1'b0, custom_channel_one});
        wr(`STCD_PG_CHAN, 2'h0, 8'h25);
        $display("test reset done");
    endtask : t_reset

    task automatic t_polarity;
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        wr(`STCD_PG_INPUT, `STCD_LN_INPUT, 8'h01);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 1'b1);
        wr(`STCD_PG_INPUT, `STCD_LN_INPUT, 8'h00);
        $display("test polarity done");
    endtask : t_polarity

    // Both contacts closed, each disable combination
    task automatic t_aux;
        logic [1:0] d;
        for (int i = 0; i < 4; i++) begin
            d = 2'(i);
            wr(`STCD_PG_INPUT, `STCD_LN_INPUT, {5'h00, d, 1'b0});
            ev(1'b0, 1'b1, 1'b1, 1'b1);
            chk_bit("aux_a_conn", !d[0], aux_a_conn);
            chk_bit("aux_b_conn", !d[1], aux_b_conn);
            chk("status_value", {5'h00, !d[1], !d[0], 1'b0}, status_value);
        end
        wr(`STCD_PG_INPUT, `STCD_LN_INPUT, 8'h00);
        $display("test aux done");
    endtask : t_aux

    task automatic t_radio;
        wr(`STCD_PG_RADIO, `STCD_LN_RADIO, 8'h11);
        rd(`STCD_PG_RADIO, `STCD_LN_RADIO, 8'h11);
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        chk_bit("proto_zgp", 1'b1, proto_zgp);
        chk_bit("tx_pwr_low", 1'b1, tx_pwr_low);
        wr(`STCD_PG_RADIO, `STCD_LN_RADIO, 8'h10);
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        chk_bit("proto_zgp", 1'b0, proto_zgp);
        chk_bit("tx_pwr_low", 1'b1, tx_pwr_low);
        wr(`STCD_PG_RADIO, `STCD_LN_RADIO, 8'h00);
        $display("test radio done");
    endtask : t_radio

    // Every plan code; odd codes also set rate, spacing, address and encoding
    task automatic t_ble;
        logic [7:0] d;
        for (int p = 0; p < 8; p++) begin
            d = {1'b0, {4{p[0]}}, 3'(p)};
            wr(`STCD_PG_BLE, `STCD_LN_BLE, d);
            rd(`STCD_PG_BLE, `STCD_LN_BLE, d);
            ev(1'b0, 1'b0, 1'b0, 1'b1);
            chk("plan", plan_exp[p], plan_byte);
            chk_bit("air_rate_2m", p[0], air_rate_2m);
            chk_bit("spacing_10ms", p[0], spacing_10ms);
            chk_bit("addr_rpa", p[0], addr_rpa);
            chk_bit("status_user", p[0], status_user);
        end
        wr(`STCD_PG_BLE, `STCD_LN_BLE, 8'h00);
        $display("test ble done");
    endtask : t_ble

    task automatic t_user;
        wr(`STCD_PG_USR_LO, 2'h1, 8'hA5);
        wr(`STCD_PG_USR_HI, 2'h3, 8'h5A);
        rd(`STCD_PG_USR_LO, 2'h1, 8'hA5);
        wr(`STCD_PG_BLE, `STCD_LN_BLE, 8'h40);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        chk("status_value", 8'hA5, status_value);
        ev(1'b1, 1'b1, 1'b1, 1'b0);
        chk("status_value", 8'h5A, status_value);
        wr(`STCD_PG_BLE, `STCD_LN_BLE, 8'h00);
        $display("test user done");
    endtask : t_user

    // A new setting waits for an event taken while the transmitter is idle
    task automatic t_hold;
        wr(`STCD_PG_RADIO, `STCD_LN_RADIO, 8'h01);
        repeat (3) @(negedge clk_sys);
        chk_bit("proto_zgp", 1'b0, proto_zgp);
        hold_busy = 1'b1;
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        chk_bit("proto_zgp", 1'b0, proto_zgp);
        hold_busy = 1'b0;
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        chk_bit("proto_zgp", 1'b1, proto_zgp);
        $display("test hold done");
    endtask : t_hold

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        {rstn, hold_busy, upd_we, spring_away_pin, spring_toward_pin} = 5'h00;
        {aux_contact_a_pin, aux_contact_b_pin, upd_lane, nfc_rd_lane} = 6'h00;
        {upd_page, upd_data, nfc_rd_page} = 24'h000000;
        repeat (4) @(negedge clk_sys);
        rstn = 1'b1;
        t_reset();
        t_polarity();
        t_aux();
        t_radio();
        t_ble();
        t_user();
        t_hold();
        final_report();
    end

    // Whole run needs under a thousand cycles; this margin only catches a hang
    initial begin
        #(25 * 20000);
        num_errors++;
        final_report();
    end
endmodule : switch_tx_config_decode_tb_top

`default_nettype wire
